// ===== design/cwd_pkg.sv
// Purpose: Shared constants and types for the crystal clocked watchdog
// Assumes: Control register reached over the special-function register port
// Notes: Timeouts are counted in crystal ticks, not system clocks
package cwd_pkg;
   localparam logic [7:0] CTL_ADDR = 8'hc0;
   localparam int PRE_MSB = 7;
   localparam int PRE_LSB = 4;
   localparam int IRQ_SEL_BIT = 3;
   localparam int FLAG_BIT = 2;
   localparam int RUN_BIT = 1;
   localparam int UNLOCK_BIT = 0;
   localparam logic [3:0] PRE_RESET = 4'h7;
   localparam logic [3:0] PRE_AUTO_RESET = 4'h8;
   localparam logic [3:0] PRE_DOWNLOAD = 4'h9;
   localparam logic RUN_RESET = 1'b1;
   localparam logic IRQ_SEL_RESET = 1'b0;
   localparam int CRYSTAL_HZ = 32768;
   // 15.6 ms at code zero is 512 crystal ticks; each code doubles it
   localparam int BASE_SHIFT = 9;
   localparam int CNT_W = 16;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cwd_sfr_req_t;

   typedef enum logic [1:0] {
      UL_IDLE = 2'b01,
      UL_ARMED = 2'b10
   } cwd_unlock_t;
endpackage : cwd_pkg

// ===== design/cwd_counter.sv
// Purpose: 16-bit crystal tick counter with selectable expiry bit
// Assumes: tick is a one-cycle pulse per crystal period
// Notes: Counter returns to zero on clear or on expiry
`timescale 1ns/100ps
module cwd_counter (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tick,
   input wire logic clear,
   input wire logic [2:0] sel,
   output logic expire
);
   logic [cwd_pkg::CNT_W-1:0] count_ff;
   logic [cwd_pkg::CNT_W:0] limit;

   always_comb begin
      limit = 17'(17'h1 << (cwd_pkg::BASE_SHIFT + int'(sel))) - 17'h1;
      expire = tick && ({1'b0, count_ff} == limit);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_ff <= '0;
      end else if (clear || expire) begin
         count_ff <= '0;
      end else if (tick) begin
         count_ff <= count_ff + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_COUNT_ON_TICK: assert property (@(posedge clk_sys) disable iff (rst)
      !tick && !clear |=> count_ff == $past(count_ff))
      else $error("Counter moved without crystal tick");
endmodule : cwd_counter

// ===== design/cwd_watchdog.sv
// Purpose: Watchdog with guarded control register and reset or interrupt response
// Assumes: crystal_in sampled as a synchronous level; rst is the external pin reset
// Notes: Self reset restores configuration but keeps the timeout flag
// Functional notes
// - Reset state: running, two second code, reset
// - Enable zero blocks every reset and interrupt
// - Counter advances on rising crystal edges only
// - 16-bit counter, code picks expiry bit
// - Codes zero to seven double from 15.6ms
// - Code 1000/1001 reset immediately, second to download
// - Response bit selects reset or interrupt
// - Any timeout sets the status flag
// - Flag clears by written zero or pin reset
// - Watchdog reset leaves the flag set
// - Writing enable one restarts counter from zero
// - Control write accepted only after unlock
// - Lock bit low forces enable on, reset response
// - Protection ignores enable and response changes
// - Protection still allows timeout code writes
// - Interrupt is unmaskable by global enable
`timescale 1ns/100ps
module cwd_watchdog (
   input wire logic clk_sys,
   input wire logic rst,
   input wire cwd_pkg::cwd_sfr_req_t sfr,
   output logic [7:0] sfr_rdata,
   input wire logic crystal_in,
   input wire logic protection_lock_bit,
   output logic wdt_sys_reset,
   output logic wdt_download_reset,
   output logic wdt_irq
);
   cwd_pkg::cwd_unlock_t unlock_ff;
   logic crystal_d_ff;
   logic [3:0] pre_ff;
   logic irq_sel_ff;
   logic run_ff;
   logic timeout_flag_ff;
   logic [7:0] rdata_ff;
   logic sys_reset_ff;
   logic download_ff;
   logic irq_ff;
   logic tick;
   logic protect;
   logic eff_run;
   logic eff_irq;
   logic ctl_wr;
   logic ctl_rd;
   logic accept;
   logic kick;
   logic [3:0] wr_pre;
   logic new_run;
   logic imm_auto;
   logic imm_dl;
   logic expire;
   logic exp_reset;
   logic exp_irq;
   logic self_reset;
   logic timeout_evt;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   always_comb begin
      tick = crystal_in && !crystal_d_ff;
      protect = !protection_lock_bit;
      eff_run = protect ? 1'b1 : run_ff;
      eff_irq = protect ? 1'b0 : irq_sel_ff;
      ctl_wr = sfr.wr && (sfr.addr == cwd_pkg::CTL_ADDR);
      ctl_rd = sfr.rd && (sfr.addr == cwd_pkg::CTL_ADDR);
      accept = ctl_wr && (unlock_ff == cwd_pkg::UL_ARMED);
      wr_pre = sfr.wdata[cwd_pkg::PRE_MSB:cwd_pkg::PRE_LSB];
      kick = accept && sfr.wdata[cwd_pkg::RUN_BIT];
      new_run = protect ? 1'b1 : sfr.wdata[cwd_pkg::RUN_BIT];
      imm_auto = accept && new_run && (wr_pre == cwd_pkg::PRE_AUTO_RESET);
      imm_dl = accept && new_run && (wr_pre == cwd_pkg::PRE_DOWNLOAD);
      exp_reset = expire && eff_run && !eff_irq;
      exp_irq = expire && eff_run && eff_irq;
      self_reset = exp_reset || imm_auto || imm_dl;
      timeout_evt = self_reset || exp_irq;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         crystal_d_ff <= 1'b0;
      end else begin
         crystal_d_ff <= crystal_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter; clears on kick, stop or self reset, and wraps after interrupt
   cwd_counter u_counter (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(tick),
      .clear(kick || !eff_run || self_reset),
      .sel(pre_ff[2:0]),
      .expire(expire)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Unlock sequence
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         unlock_ff <= cwd_pkg::UL_IDLE;
      end else if (unlock_ff == cwd_pkg::UL_ARMED) begin
         if (sfr.wr || sfr.rd) begin
            unlock_ff <= cwd_pkg::UL_IDLE;
         end
      end else if (ctl_wr && sfr.wdata[cwd_pkg::UNLOCK_BIT]) begin
         unlock_ff <= cwd_pkg::UL_ARMED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pre_ff <= cwd_pkg::PRE_RESET;
         run_ff <= cwd_pkg::RUN_RESET;
         irq_sel_ff <= cwd_pkg::IRQ_SEL_RESET;
      end else if (self_reset) begin
         pre_ff <= cwd_pkg::PRE_RESET;
         run_ff <= cwd_pkg::RUN_RESET;
         irq_sel_ff <= cwd_pkg::IRQ_SEL_RESET;
      end else if (accept) begin
         pre_ff <= wr_pre;
         if (!protect) begin
            run_ff <= sfr.wdata[cwd_pkg::RUN_BIT];
            irq_sel_ff <= sfr.wdata[cwd_pkg::IRQ_SEL_BIT];
         end
      end
   end

   // Set wins over a simultaneous written zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         timeout_flag_ff <= 1'b0;
      end else if (timeout_evt) begin
         timeout_flag_ff <= 1'b1;
      end else if (accept && !sfr.wdata[cwd_pkg::FLAG_BIT]) begin
         timeout_flag_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Responses and read data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sys_reset_ff <= 1'b0;
         download_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         sys_reset_ff <= exp_reset || imm_auto;
         download_ff <= imm_dl;
         irq_ff <= exp_irq;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (ctl_rd) begin
         rdata_ff <= {pre_ff, eff_irq, timeout_flag_ff, eff_run,
                      unlock_ff == cwd_pkg::UL_ARMED};
      end else if (sfr.rd) begin
         rdata_ff <= 8'h00;
      end
   end

   assign sfr_rdata = rdata_ff;
   assign wdt_sys_reset = sys_reset_ff;
   assign wdt_download_reset = download_ff;
   assign wdt_irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_unlock;
      ctl_wr && sfr.wdata[cwd_pkg::UNLOCK_BIT] && unlock_ff == cwd_pkg::UL_IDLE;
   endsequence
   sequence s_guarded_write;
      ctl_wr && !sfr.wdata[cwd_pkg::UNLOCK_BIT];
   endsequence
   sequence s_auto_code;
      accept && new_run && wr_pre == cwd_pkg::PRE_AUTO_RESET;
   endsequence
   sequence s_dl_code;
      accept && new_run && wr_pre == cwd_pkg::PRE_DOWNLOAD;
   endsequence

   AST_NO_OUT_WHEN_OFF: assert property (
      !eff_run && !kick |=> !wdt_sys_reset && !wdt_irq && !wdt_download_reset)
      else $error("Watchdog response while disabled");
   AST_TICK_ONLY_COUNTS: assert property (expire |-> tick)
      else $error("Expiry without crystal tick");
   AST_RESP_SELECT: assert property (
      expire && eff_run && !kick |=> wdt_irq == $past(eff_irq)
         && wdt_sys_reset == !$past(eff_irq))
      else $error("Wrong timeout response");
   AST_FLAG_SET: assert property (timeout_evt |=> timeout_flag_ff)
      else $error("Timeout flag not set");
   AST_FLAG_KEEP: assert property (!accept && timeout_flag_ff |=> timeout_flag_ff)
      else $error("Flag cleared without written zero");
   AST_FLAG_CLEAR: assert property (
      accept && !sfr.wdata[cwd_pkg::FLAG_BIT] && !timeout_evt |=> !timeout_flag_ff)
      else $error("Written zero did not clear flag");
   AST_SELF_RESET_FLAG: assert property (
      self_reset |=> timeout_flag_ff && pre_ff == cwd_pkg::PRE_RESET)
      else $error("Self reset lost flag or config");
   AST_IMM_AUTO: assert property (s_auto_code |=> wdt_sys_reset && !wdt_download_reset)
      else $error("Immediate reset code not acted on");
   AST_IMM_DL: assert property (s_dl_code |=> wdt_download_reset && !wdt_sys_reset)
      else $error("Download reset code not acted on");
   AST_UNLOCKED_WRITE: assert property (
      s_unlock ##1 s_guarded_write |=> pre_ff == $past(wr_pre) || $past(self_reset))
      else $error("Unlocked write not taken");
   AST_LOCKED_IGNORED: assert property (
      ctl_wr && unlock_ff == cwd_pkg::UL_IDLE |=> $stable(pre_ff) || $past(self_reset))
      else $error("Write taken without unlock");
   AST_PROTECT_FORCE: assert property (!protection_lock_bit |-> eff_run && !eff_irq)
      else $error("Protection not forcing config");
   AST_PROTECT_RESET: assert property (protect && expire |=> wdt_sys_reset && !wdt_irq)
      else $error("Protected expiry did not reset");
   AST_PROTECT_HOLD: assert property (
      protect && accept && !self_reset |=> run_ff == $past(run_ff)
         && irq_sel_ff == $past(irq_sel_ff))
      else $error("Protected enable or response changed");
   AST_UNLOCK_ONCE: assert property (
      unlock_ff == cwd_pkg::UL_ARMED && (sfr.wr || sfr.rd) |=> unlock_ff == cwd_pkg::UL_IDLE)
      else $error("Unlock survived an access");
endmodule : cwd_watchdog

// ===== verification/cwd_watchdog_tb.sv
// Purpose: Self-checking bench for the crystal clocked watchdog
// Assumes: Crystal toggles every system clock, one tick per two clocks
// Notes: Code zero expires after 512 ticks, about 1024 system clocks
`timescale 1ns/100ps
module cwd_watchdog_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   cwd_pkg::cwd_sfr_req_t sfr = '0;
   logic [7:0] sfr_rdata;
   logic crystal_in = 1'b0;
   logic protection_lock_bit = 1'b1;
   logic wdt_sys_reset;
   logic wdt_download_reset;
   logic wdt_irq;
   int num_errors = 0;
   int checks = 0;
   int n;
   logic [2:0] which;
   logic [7:0] rows [3][2] = '{'{8'h32, 8'h32}, '{8'h5a, 8'h5a}, '{8'h08, 8'h08}};

   cwd_watchdog u_cwd_watchdog (.clk_sys(clk_sys), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
      .crystal_in(crystal_in), .protection_lock_bit(protection_lock_bit),
      .wdt_sys_reset(wdt_sys_reset), .wdt_download_reset(wdt_download_reset), .wdt_irq(wdt_irq));

   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) crystal_in <= ~crystal_in;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic access(input logic w, input logic r, input logic [7:0] d);
      @(posedge clk_sys);
      sfr <= cwd_pkg::cwd_sfr_req_t'{cwd_pkg::CTL_ADDR, w, r, d};
   endtask : access

   task automatic idle;
      @(posedge clk_sys);
      sfr <= '0;
   endtask : idle

   task automatic rd(input logic [7:0] exp);
      access(1'b0, 1'b1, 8'h00);
      idle();
      @(posedge clk_sys);
      #1;
      chk("control_read", exp, sfr_rdata);
   endtask : rd

   task automatic cwr(input logic [7:0] d);
      access(1'b1, 1'b0, 8'h01);
      access(1'b1, 1'b0, d);
      idle();
   endtask : cwr

   task automatic wait_evt(input int lim, input logic need);
      n = 0;
      #1;
      which = {wdt_download_reset, wdt_sys_reset, wdt_irq};
      while (which == 3'b000 && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
         which = {wdt_download_reset, wdt_sys_reset, wdt_irq};
      end
      if (need && which == 3'b000) begin
         num_errors++;
         $display("MISMATCH event_wait expected pulse seen none");
         end_sim();
      end
   endtask : wait_evt

   task automatic pin_reset;
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
   endtask : pin_reset

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'h72);
      foreach (rows[i]) begin
         cwr(rows[i][0]);
         rd(rows[i][1]);
      end
      access(1'b1, 1'b0, 8'h72);
      idle();
      rd(8'h08);
      access(1'b1, 1'b0, 8'h01);
      idle();
      rd(8'h09);
      access(1'b1, 1'b0, 8'h72);
      idle();
      rd(8'h08);
      wait_evt(1200, 1'b0);
      chk("disabled_pulses", 8'h00, {5'h00, which});
      cwr(8'h0a);
      wait_evt(1100, 1'b1);
      chk("irq_first", 8'h01, {5'h00, which});
      chk("irq_delay", 8'h01, {7'h00, n >= 990 && n <= 1040});
      rd(8'h0e);
      wait_evt(1100, 1'b1);
      chk("irq_again", 8'h01, {5'h00, which});
      chk("irq_again_delay", 8'h01, {7'h00, n >= 990 && n <= 1040});
      cwr(8'h1a);
      wait_evt(2200, 1'b1);
      chk("code_one_irq", 8'h01, {5'h00, which});
      chk("code_one_delay", 8'h01, {7'h00, n >= 2000 && n <= 2100});
      cwr(8'h02);
      rd(8'h02);
      wait_evt(600, 1'b0);
      chk("kick_hold", 8'h00, {5'h00, which});
      cwr(8'h02);
      wait_evt(1100, 1'b1);
      chk("reset_response", 8'h02, {5'h00, which});
      chk("reset_delay", 8'h01, {7'h00, n >= 990 && n <= 1040});
      rd(8'h76);
      cwr(8'h82);
      wait_evt(3, 1'b1);
      chk("auto_reset", 8'h02, {5'h00, which});
      cwr(8'h92);
      wait_evt(3, 1'b1);
      chk("download_reset", 8'h04, {5'h00, which});
      pin_reset();
      rd(8'h72);
      @(posedge clk_sys);
      protection_lock_bit <= 1'b0;
      cwr(8'h08);
      rd(8'h02);
      wait_evt(1100, 1'b1);
      chk("protect_response", 8'h02, {5'h00, which});
      end_sim();
   end
endmodule : cwd_watchdog_tb
